// file: rtl/esq_arb_if.sv
// Link between the sequencer and its request latch and arbiter.
`timescale 1ns/1ps
interface esq_arb_if #(parameter int N_SRC = 8);
  logic [N_SRC-1:0]         req;       // Raw request levels.
  logic [N_SRC-1:0]         en;        // Per-source enables.
  logic                     imask;     // Global mask.
  logic                     served;    // Held request has been vectored.
  logic                     grant_v;   // A request is held.
  logic [$clog2(N_SRC)-1:0] grant_idx; // Index of the held request.

  modport ctl (output req, en, imask, served, input grant_v, grant_idx);
  modport arb (input req, en, imask, served, output grant_v, grant_idx);
endinterface : esq_arb_if

// file: rtl/esq_arbiter.sv
// Request latches and the held-winner arbiter.
`timescale 1ns/1ps
module esq_arbiter
  import esq_pkg::*;
#(
  parameter int N_SRC = N_SRC_DEF
) (
  input  wire logic clk_i,   // System clock.
  input  wire logic rst_n_i, // Asynchronous reset, active low.
  esq_arb_if.arb    arb      // Sequencer side.
);

  localparam int IW = $clog2(N_SRC);

  typedef struct packed {
    logic [N_SRC-1:0] pend;
    logic             held_v;
    logic [IW-1:0]    held_idx;
    logic             imask_d;
  } esq_arb_s;

  esq_arb_s r;
  esq_arb_s n;

  // Lowest index wins; index 0 is the highest priority source.
  function automatic logic [IW-1:0] first_set(input logic [N_SRC-1:0] v);
    first_set = '0;
    for (int i = N_SRC - 1; i >= 0; i--) begin
      if (v[i]) begin
        first_set = IW'(i);
      end
    end
  endfunction : first_set

  // ----------------------------------------------------------------------------------------------
  // Latching and arbitration
  // ----------------------------------------------------------------------------------------------
  // A new request always wins over the clear of the same latch in one cycle.
  always_comb begin
    n          = r;
    n.imask_d  = arb.imask;
    n.pend     = r.pend & arb.en;
    if (arb.served && r.held_v) begin
      n.pend[r.held_idx] = 1'b0;
    end
    n.pend     = n.pend | (arb.req & arb.en);
    // The held winner is released only when vectored or when the mask is cleared.
    if (arb.served || (r.imask_d && !arb.imask)) begin
      n.held_v = 1'b0;
    end
    if (!n.held_v && !arb.imask && (|r.pend)) begin
      n.held_v   = 1'b1;
      n.held_idx = first_set(r.pend);
    end
  end

  // State register.
  always_ff @(posedge clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      r <= '{pend: '0, held_v: 1'b0, held_idx: '0, imask_d: 1'b1};
    end else begin
      r <= n;
    end
  end

  assign arb.grant_v   = r.held_v;
  assign arb.grant_idx = r.held_idx;

endmodule : esq_arbiter

// file: rtl/esq_pkg.sv
// Shared constants, state codes and the sequencer state record for the exception sequencer.
package esq_pkg;

  // ----------------------------------------------------------------------------------------------
  // Sizes and codes
  // ----------------------------------------------------------------------------------------------
  localparam int          N_SRC_DEF   = 8;         // Default count of hardware request lines.
  localparam logic [15:0] VEC_TOP     = 16'hfffe;  // Vector of code zero (reset).
  localparam logic [4:0]  CODE_RST    = 5'h00;     // Reset vector selector.
  localparam logic [4:0]  CODE_SWI    = 5'h01;     // Software interrupt and break selector.
  localparam logic [4:0]  CODE_HW0    = 5'h02;     // Selector of hardware line 0.
  localparam logic [2:0]  LAST_STEP   = 3'h4;      // Five stacked bytes, steps 0 to 4.
  localparam logic [15:0] STACK_FRAME = 16'h0005;  // Stack pointer movement per frame.
  localparam int          I_BIT       = 3;         // Position of the mask in the condition codes.

  // ----------------------------------------------------------------------------------------------
  // Sequencer states and state record
  // ----------------------------------------------------------------------------------------------
  typedef enum logic [2:0] {
    ST_IDLE = 3'b000,
    ST_PUSH = 3'b001,
    ST_VECH = 3'b010,
    ST_VECL = 3'b011,
    ST_PULL = 3'b100
  } esq_state_e;

  typedef struct packed {
    esq_state_e  st;
    logic [2:0]  step;
    logic [4:0]  code;
    logic        hw;
    logic        imask;
    logic        rti_end;
    logic [15:0] sp;
    logic [15:0] pc;
    logic [7:0]  a;
    logic [7:0]  x;
    logic [7:0]  ccr;
    logic [7:0]  vech;
    logic [15:0] addr;
    logic [7:0]  wdata;
    logic        rd;
    logic        wr;
    logic        pc_ld;
    logic        reg_ld;
    logic        sp_ld;
    logic        served;
  } esq_seq_s;

  // Out of reset the sequencer is already reading the reset vector high byte with the mask set.
  localparam esq_seq_s SEQ_RST = '{st: ST_VECH, step: 3'h0, code: CODE_RST, hw: 1'b0,
                                   imask: 1'b1, rti_end: 1'b0, sp: 16'h0000, pc: 16'h0000,
                                   a: 8'h00, x: 8'h00, ccr: 8'h00, vech: 8'h00,
                                   addr: VEC_TOP, wdata: 8'h00, rd: 1'b1, wr: 1'b0,
                                   pc_ld: 1'b0, reg_ld: 1'b0, sp_ld: 1'b0, served: 1'b0};

  // Vector address of a selector: two bytes per entry counting down from the top.
  function automatic logic [15:0] vec_addr(input logic [4:0] code);
    vec_addr = VEC_TOP - {10'h000, code, 1'b0};
  endfunction : vec_addr

endpackage : esq_pkg

// file: rtl/esq_sequencer.sv
// Exception sequencer of the system integration unit: entry, vector fetch and return.
`timescale 1ns/1ps
module esq_sequencer
  import esq_pkg::*;
#(
  parameter int N_SRC = N_SRC_DEF
) (
  input  wire logic             CLK_SYS_I,    // System clock, 50 MHz.
  input  wire logic             RST_N_I,      // Asynchronous reset, active low.
  input  wire logic [N_SRC-1:0] IRQ_REQ_I,    // Hardware request levels.
  input  wire logic [N_SRC-1:0] IRQ_EN_I,     // Per-source enable bits.
  input  wire logic             INSTR_DONE_I, // Core finished an instruction.
  input  wire logic             SWI_EXEC_I,   // That instruction was a software interrupt.
  input  wire logic             RTI_EXEC_I,   // That instruction was a return from interrupt.
  input  wire logic             BRK_REQ_I,    // Break request level.
  input  wire logic             IMASK_WR_I,   // Core writes the global mask.
  input  wire logic             IMASK_VAL_I,  // Value written to the mask.
  input  wire logic [15:0]      PC_I,         // Core program counter.
  input  wire logic [15:0]      SP_I,         // Core stack pointer.
  input  wire logic [7:0]       A_I,          // Core accumulator.
  input  wire logic [7:0]       X_I,          // Core index low register.
  input  wire logic [7:0]       CCR_I,        // Core condition codes.
  input  wire logic [7:0]       RDATA_I,      // Memory read data.
  output logic [15:0]           ADDR_O,       // Memory address.
  output logic [7:0]            WDATA_O,      // Memory write data.
  output logic                  RD_O,         // Memory read strobe.
  output logic                  WR_O,         // Memory write strobe.
  output logic                  CORE_HOLD_O,  // Core must stall.
  output logic [4:0]            VEC_SEL_O,    // Vector selector constant.
  output logic                  IMASK_O,      // Global interrupt mask.
  output logic                  PC_LOAD_O,    // Load PC_NEW_O into the core.
  output logic [15:0]           PC_NEW_O,     // New program counter.
  output logic                  SP_LOAD_O,    // Load SP_NEW_O into the core.
  output logic [15:0]           SP_NEW_O,     // New stack pointer.
  output logic                  REG_LOAD_O,   // Load restored registers.
  output logic [7:0]            A_NEW_O,      // Restored accumulator.
  output logic [7:0]            X_NEW_O,      // Restored index low register.
  output logic [7:0]            CCR_NEW_O     // Restored condition codes.
);

  // ----------------------------------------------------------------------------------------------
  // Request latch and arbiter
  // ----------------------------------------------------------------------------------------------
  esq_arb_if #(.N_SRC(N_SRC)) arb_if ();

  esq_arbiter #(.N_SRC(N_SRC)) u_arb (
    .clk_i   (CLK_SYS_I),
    .rst_n_i (RST_N_I),
    .arb     (arb_if.arb)
  );

  esq_seq_s r;
  esq_seq_s n;

  // Byte written at each stacking step, low PC byte first so it lands highest in memory.
  function automatic logic [7:0] push_byte(input esq_seq_s s);
    case (s.step)
      3'h0:    push_byte = s.pc[7:0];
      3'h1:    push_byte = s.pc[15:8];
      3'h2:    push_byte = s.x;
      3'h3:    push_byte = s.a;
      default: push_byte = s.ccr;
    endcase
  endfunction : push_byte

  // ----------------------------------------------------------------------------------------------
  // Sequencer
  // ----------------------------------------------------------------------------------------------
  // Each cycle outside IDLE is one memory cycle: one per step in PUSH and PULL, one each in VECH and VECL; bus outputs are registered for the next state.
  always_comb begin
    n        = r;
    n.pc_ld  = 1'b0;
    n.reg_ld = 1'b0;
    n.sp_ld  = 1'b0;
    n.served = 1'b0;
    n.rd     = 1'b0;
    n.wr     = 1'b0;
    case (r.st)
      ST_IDLE: begin
        n.rti_end = 1'b0;
        if (IMASK_WR_I && !r.rti_end) begin
          n.imask = IMASK_VAL_I;
        end
        // The cycle after a return is itself a boundary, so a pending request is taken at once.
        if (INSTR_DONE_I || r.rti_end) begin
          if (!r.rti_end) begin
            n.sp  = SP_I;
            n.a   = A_I;
            n.x   = X_I;
            n.ccr = CCR_I;
            n.pc  = PC_I;
          end else begin
            n.pc  = r.pc + 16'h0001;
          end
          n.ccr[I_BIT] = n.imask;
          n.step       = 3'h0;
          n.hw         = 1'b0;
          if (!r.rti_end && RTI_EXEC_I) begin
            n.st = ST_PULL;
          end else if (!r.rti_end && SWI_EXEC_I) begin
            n.st    = ST_PUSH;
            n.code  = CODE_SWI;
            n.imask = 1'b1;
          end else if (BRK_REQ_I) begin
            n.st    = ST_PUSH;
            n.code  = CODE_SWI;
            n.pc    = n.pc - 16'h0001;
            n.imask = 1'b1;
          end else if (arb_if.grant_v && !n.imask) begin
            n.st    = ST_PUSH;
            n.code  = CODE_HW0 + 5'(arb_if.grant_idx);
            n.hw    = 1'b1;
            n.pc    = n.pc - 16'h0001;
            n.imask = 1'b1;
          end
        end
      end
      ST_PUSH: begin
        // The index high register is deliberately left off the frame.
        n.step = r.step + 3'h1;
        if (r.step == LAST_STEP) begin
          n.st = ST_VECH;
        end
      end
      ST_VECH: begin
        n.vech = RDATA_I;
        n.st   = ST_VECL;
      end
      ST_VECL: begin
        n.pc    = {r.vech, RDATA_I};
        n.pc_ld = 1'b1;
        n.st    = ST_IDLE;
        if (r.code != CODE_RST) begin
          n.sp     = r.sp - STACK_FRAME;
          n.sp_ld  = 1'b1;
          n.served = r.hw;
        end
      end
      ST_PULL: begin
        n.step = r.step + 3'h1;
        case (r.step)
          3'h0:    n.ccr       = RDATA_I;
          3'h1:    n.a         = RDATA_I;
          3'h2:    n.x         = RDATA_I;
          3'h3:    n.pc[15:8]  = RDATA_I;
          default: n.pc[7:0]   = RDATA_I;
        endcase
        if (r.step == LAST_STEP) begin
          n.st      = ST_IDLE;
          n.sp      = r.sp + STACK_FRAME;
          n.imask   = r.ccr[I_BIT];
          n.pc_ld   = 1'b1;
          n.sp_ld   = 1'b1;
          n.reg_ld  = 1'b1;
          n.rti_end = 1'b1;
        end
      end
      default: begin
        n = SEQ_RST;
      end
    endcase
    // Bus cycle of the state about to be entered.
    case (n.st)
      ST_PUSH: begin
        n.wr    = 1'b1;
        n.addr  = n.sp - {13'h0000, n.step};
        n.wdata = push_byte(n);
      end
      ST_VECH: begin
        n.rd   = 1'b1;
        n.addr = vec_addr(n.code);
      end
      ST_VECL: begin
        n.rd   = 1'b1;
        n.addr = vec_addr(n.code) + 16'h0001;
      end
      ST_PULL: begin
        n.rd   = 1'b1;
        n.addr = n.sp + 16'h0001 + {13'h0000, n.step};
      end
      default: begin
        n.addr = r.addr;
      end
    endcase
  end

  // State register; reset starts the reset-vector fetch directly.
  always_ff @(posedge CLK_SYS_I or negedge RST_N_I) begin
    if (!RST_N_I) begin
      r <= SEQ_RST;
    end else begin
      r <= n;
    end
  end

  // ----------------------------------------------------------------------------------------------
  // Outputs
  // ----------------------------------------------------------------------------------------------
  // Arbiter sees the registered mask, so a mask clear releases its held winner.
  // On the last pull the restored mask is shown one cycle early, so that a winner already
  // stands in the boundary cycle after a return and a pending request is taken there.
  assign arb_if.req    = IRQ_REQ_I;
  assign arb_if.en     = IRQ_EN_I;
  assign arb_if.imask  = ((r.st == ST_PULL) && (r.step == LAST_STEP)) ? r.ccr[I_BIT]
                                                                       : r.imask;
  assign arb_if.served = r.served;

  // Hold covers the boundary cycle after a return, when a pending request may still enter.
  assign CORE_HOLD_O = (r.st != ST_IDLE) || r.rti_end;
  assign ADDR_O      = r.addr;
  assign WDATA_O     = r.wdata;
  assign RD_O        = r.rd;
  assign WR_O        = r.wr;
  assign VEC_SEL_O   = r.code;
  assign IMASK_O     = r.imask;
  assign PC_LOAD_O   = r.pc_ld;
  assign PC_NEW_O    = r.pc;
  assign SP_LOAD_O   = r.sp_ld;
  assign SP_NEW_O    = r.sp;
  assign REG_LOAD_O  = r.reg_ld;
  assign A_NEW_O     = r.a;
  assign X_NEW_O     = r.x;
  assign CCR_NEW_O   = r.ccr;

endmodule : esq_sequencer

// file: sim/esq_mem_model.sv
// Zero-wait byte memory standing for the core's bus.
`timescale 1ns/1ps
module esq_mem_model (
  input  wire logic        clk_i,   // System clock.
  input  wire logic [15:0] addr_i,  // Address.
  input  wire logic [7:0]  wdata_i, // Write data.
  input  wire logic        rd_i,    // Read strobe.
  input  wire logic        wr_i,    // Write strobe.
  output logic [7:0]       rdata_o  // Read data.
);
  logic [7:0] mem [0:65535];
  logic [7:0] last_r;

  // Fill with a marker so stray writes show up.
  initial begin
    for (int i = 0; i < 65536; i++) mem[i] = 8'h5a;
    last_r = 8'h00;
  end

  // Writes land at the edge; an idle bus shows the inverse of the last byte, not stale data.
  always @(posedge clk_i) begin
    if (wr_i) mem[addr_i] <= wdata_i;
    if (rd_i) last_r <= mem[addr_i];
  end
  assign rdata_o = rd_i ? mem[addr_i] : ~last_r;
endmodule : esq_mem_model

// file: sim/esq_seq_monitor.sv
// Concurrent checks on the exception sequencer's ports.
`timescale 1ns/1ps
module esq_seq_monitor (
  input wire logic        CLK_SYS_I,    // System clock.
  input wire logic        RST_N_I,      // Reset, active low.
  input wire logic        INSTR_DONE_I, // Instruction boundary.
  input wire logic        SWI_EXEC_I,   // Software interrupt done.
  input wire logic        RTI_EXEC_I,   // Return done.
  input wire logic        BRK_REQ_I,    // Break request.
  input wire logic [7:0]  RDATA_I,      // Read data.
  input wire logic [15:0] ADDR_O,       // Address.
  input wire logic        RD_O,         // Read strobe.
  input wire logic        WR_O,         // Write strobe.
  input wire logic        CORE_HOLD_O,  // Core stall.
  input wire logic [4:0]  VEC_SEL_O,    // Vector selector.
  input wire logic        IMASK_O,      // Global mask.
  input wire logic        PC_LOAD_O,    // PC load pulse.
  input wire logic [15:0] PC_NEW_O,     // New PC.
  input wire logic        SP_LOAD_O,    // SP load pulse.
  input wire logic [15:0] SP_NEW_O,     // New SP.
  input wire logic        REG_LOAD_O    // Register restore pulse.
);
  // ----------------------------------------------------------------------------
  // Entry and return sequence checks
  // ----------------------------------------------------------------------------
  default clocking cb @(posedge CLK_SYS_I); endclocking
  default disable iff (!RST_N_I);

  // Five pushes, then the vector pair read high byte first.
  sequence s_push5;
    WR_O [*5];
  endsequence
  sequence s_vec2;
    (RD_O && !WR_O && ADDR_O == 16'hfffe - {10'h000, VEC_SEL_O, 1'b0})
    ##1 (RD_O && ADDR_O == 16'hffff - {10'h000, VEC_SEL_O, 1'b0});
  endsequence

  chk_push_hold: assert property (WR_O |-> CORE_HOLD_O && IMASK_O)
    else $error("push without stall or mask");
  chk_push_order: assert property (
    WR_O && $past(WR_O) |-> ADDR_O == $past(ADDR_O) - 16'h0001)
    else $error("push address not descending");
  chk_entry_steps: assert property ($rose(WR_O) |-> s_push5 ##1 s_vec2 ##1 PC_LOAD_O)
    else $error("entry sequence out of order");
  chk_pc_source: assert property (
    PC_LOAD_O |-> PC_NEW_O == {$past(RDATA_I, 2), $past(RDATA_I)})
    else $error("new PC not from read bytes");
  chk_sp_entry: assert property (
    $fell(WR_O) |-> ##2 SP_LOAD_O && SP_NEW_O == $past(ADDR_O, 3) - 16'h0001)
    else $error("stack frame size wrong");
  chk_pull_load: assert property (
    REG_LOAD_O |-> PC_LOAD_O && SP_LOAD_O && SP_NEW_O == $past(ADDR_O) && $past(RD_O, 5))
    else $error("return restore wrong");
  chk_load_pulse: assert property (PC_LOAD_O |=> !PC_LOAD_O)
    else $error("PC load longer than one cycle");
  chk_swi_taken: assert property (
    INSTR_DONE_I && SWI_EXEC_I && !RTI_EXEC_I && !CORE_HOLD_O
    |=> WR_O && VEC_SEL_O == 5'h01 && IMASK_O)
    else $error("software interrupt not taken");
  chk_mask_blocks: assert property (
    INSTR_DONE_I && !SWI_EXEC_I && !RTI_EXEC_I && !BRK_REQ_I
    && IMASK_O && !CORE_HOLD_O |=> !CORE_HOLD_O)
    else $error("entry taken while masked");
endmodule : esq_seq_monitor

// file: sim/esq_sequencer_test.sv
// Self-checking bench of the exception sequencer.
`timescale 1ns/1ps
module esq_sequencer_test;
  import esq_pkg::*;
  logic CLK_SYS_I, RST_N_I, INSTR_DONE_I, SWI_EXEC_I, RTI_EXEC_I, BRK_REQ_I;
  logic IMASK_WR_I, IMASK_VAL_I, RD_O, WR_O, CORE_HOLD_O, IMASK_O;
  logic PC_LOAD_O, SP_LOAD_O, REG_LOAD_O;
  logic [7:0]  IRQ_REQ_I, IRQ_EN_I, RDATA_I, WDATA_O, A_NEW_O, X_NEW_O, CCR_NEW_O;
  logic [15:0] PC_I, SP_I, ADDR_O, PC_NEW_O, SP_NEW_O;
  logic [4:0]  VEC_SEL_O;
  int fail_count = 0;
  int num_checks = 0;

  esq_sequencer #(.N_SRC(8)) uut (.CLK_SYS_I(CLK_SYS_I), .RST_N_I(RST_N_I),
    .IRQ_REQ_I(IRQ_REQ_I), .IRQ_EN_I(IRQ_EN_I), .INSTR_DONE_I(INSTR_DONE_I),
    .SWI_EXEC_I(SWI_EXEC_I), .RTI_EXEC_I(RTI_EXEC_I), .BRK_REQ_I(BRK_REQ_I),
    .IMASK_WR_I(IMASK_WR_I), .IMASK_VAL_I(IMASK_VAL_I), .PC_I(PC_I), .SP_I(SP_I),
    .A_I(8'h11), .X_I(8'h22), .CCR_I(8'h61), .RDATA_I(RDATA_I), .ADDR_O(ADDR_O),
    .WDATA_O(WDATA_O), .RD_O(RD_O), .WR_O(WR_O), .CORE_HOLD_O(CORE_HOLD_O),
    .VEC_SEL_O(VEC_SEL_O), .IMASK_O(IMASK_O), .PC_LOAD_O(PC_LOAD_O), .PC_NEW_O(PC_NEW_O),
    .SP_LOAD_O(SP_LOAD_O), .SP_NEW_O(SP_NEW_O), .REG_LOAD_O(REG_LOAD_O),
    .A_NEW_O(A_NEW_O), .X_NEW_O(X_NEW_O), .CCR_NEW_O(CCR_NEW_O));
  esq_mem_model mem_i (.clk_i(CLK_SYS_I), .addr_i(ADDR_O), .wdata_i(WDATA_O), .rd_i(RD_O),
    .wr_i(WR_O), .rdata_o(RDATA_I));

  // ----------------------------------------------------------------------------
  // Helpers
  // ----------------------------------------------------------------------------
  initial begin
    CLK_SYS_I = 1'b0;
    forever #10 CLK_SYS_I = ~CLK_SYS_I;
  end

  task automatic ck(input logic [15:0] got, input logic [15:0] exp, input string what);
    num_checks++;
    if (got !== exp) begin
      fail_count++;
      $display("FAIL %0t %s got %h expected %h", $time, what, got, exp);
    end
  endtask : ck

  task automatic print_verdict();
    $display("checks %0d mismatches %0d", num_checks, fail_count);
    if (fail_count == 0 && num_checks > 0) $display("ALL CHECKS OK");
    else $display("CHECKS NOT OK");
    $finish;
  endtask : print_verdict

  // Instruction boundaries are only seen while the core is not stalled, so wait for that first.
  task automatic boundary(input logic [15:0] pc, input logic [15:0] sp, input logic software_interrupt_instr,
                          input logic return_from_interrupt_instr);
    for (int n = 0; n < 40 && CORE_HOLD_O !== 1'b0; n++) @(negedge CLK_SYS_I);
    @(posedge CLK_SYS_I);
    INSTR_DONE_I <= 1'b1; SWI_EXEC_I <= software_interrupt_instr; RTI_EXEC_I <= return_from_interrupt_instr; PC_I <= pc; SP_I <= sp;
    @(posedge CLK_SYS_I);
    INSTR_DONE_I <= 1'b0; SWI_EXEC_I <= 1'b0; RTI_EXEC_I <= 1'b0;
  endtask : boundary

  task automatic wait_load();
    int n;
    for (n = 0; n < 40; n++) begin
      @(negedge CLK_SYS_I);
      if (PC_LOAD_O === 1'b1) break;
    end
    ck(16'(n < 40), 16'h1, "PC load seen");
  endtask : wait_load

  task automatic set_mask(input logic v);
    for (int n = 0; n < 40 && CORE_HOLD_O !== 1'b0; n++) @(negedge CLK_SYS_I);
    @(posedge CLK_SYS_I);
    IMASK_WR_I <= 1'b1; IMASK_VAL_I <= v;
    @(posedge CLK_SYS_I);
    IMASK_WR_I <= 1'b0;
  endtask : set_mask

  // One entry: selector, handler address, frame contents and untouched byte below it.
  task automatic t_entry(input logic [15:0] pc, input logic [15:0] sp, input logic software_interrupt_instr,
                         input logic [4:0] sel, input logic [15:0] vec, input logic [15:0] stk);
    logic [7:0] ccr;
    ccr = 8'h61 | {4'h0, IMASK_O, 3'h0};
    boundary(pc, sp, software_interrupt_instr, 1'b0);
    wait_load();
    ck(16'(VEC_SEL_O), 16'(sel), "selector");
    ck(PC_NEW_O, vec, "handler address");
    ck(SP_NEW_O, sp - 16'h0005, "stack after entry");
    ck(16'(IMASK_O), 16'h1, "mask set on entry");
    ck({mem_i.mem[sp - 16'h1], mem_i.mem[sp]}, stk, "stacked PC");
    ck({mem_i.mem[sp - 16'h2], mem_i.mem[sp - 16'h3]}, 16'h2211, "stacked X and A");
    ck({8'h00, mem_i.mem[sp - 16'h4]}, {8'h00, ccr}, "stacked flags");
    ck({8'h00, mem_i.mem[sp - 16'h5]}, 16'h005a, "no sixth push");
  endtask : t_entry

  // ----------------------------------------------------------------------------
  // Main sequence
  // ----------------------------------------------------------------------------
  initial begin
    RST_N_I = 1'b0; INSTR_DONE_I = 1'b0; SWI_EXEC_I = 1'b0; RTI_EXEC_I = 1'b0;
    BRK_REQ_I = 1'b0; IMASK_WR_I = 1'b0; IMASK_VAL_I = 1'b0; IRQ_REQ_I = 8'h00;
    IRQ_EN_I = 8'h00; PC_I = 16'h0000; SP_I = 16'h0000;
    #1;
    mem_i.mem[16'hfffe] = 8'h10; mem_i.mem[16'hffff] = 8'h00;
    mem_i.mem[16'hfffc] = 8'h20; mem_i.mem[16'hfffd] = 8'h00;
    for (int i = 0; i < 8; i++) begin
      mem_i.mem[16'hfffa - 2 * i] = 8'h30 + 8'(i);
      mem_i.mem[16'hfffb - 2 * i] = 8'h00;
    end
    repeat (16) @(posedge CLK_SYS_I);
    RST_N_I <= 1'b1;
    wait_load();
    ck(PC_NEW_O, 16'h1000, "reset vector");
    ck(16'(IMASK_O), 16'h1, "mask after reset");
    IRQ_EN_I <= 8'hff; IRQ_REQ_I <= 8'h01;
    boundary(16'h1000, 16'h0080, 1'b0, 1'b0);
    repeat (3) @(negedge CLK_SYS_I);
    ck(16'(CORE_HOLD_O), 16'h0, "masked request ignored");
    IRQ_EN_I <= 8'hfe;
    set_mask(1'b0);
    boundary(16'h1000, 16'h0080, 1'b0, 1'b0);
    repeat (3) @(negedge CLK_SYS_I);
    ck(16'(CORE_HOLD_O), 16'h0, "disabled request ignored");
    IRQ_REQ_I <= 8'h12; IRQ_EN_I <= 8'hff;
    repeat (3) @(posedge CLK_SYS_I);
    t_entry(16'h4000, 16'h0080, 1'b0, 5'h03, 16'h3100, 16'h3fff);
    IRQ_REQ_I <= 8'h10;
    boundary(16'h3120, 16'h007b, 1'b0, 1'b1);
    wait_load();
    ck(16'(REG_LOAD_O), 16'h1, "restore pulse");
    ck(PC_NEW_O, 16'h3fff, "restored PC");
    ck(SP_NEW_O, 16'h0080, "restored SP");
    ck({A_NEW_O, X_NEW_O}, 16'h1122, "restored A and X");
    ck(16'(CCR_NEW_O), 16'h0061, "restored flags");
    wait_load();
    ck(16'(VEC_SEL_O), 16'h0006, "pending line after return");
    ck({mem_i.mem[16'h7f], mem_i.mem[16'h80]}, 16'h3fff, "restored PC stacked");
    IRQ_REQ_I <= 8'h00;
    t_entry(16'h5000, 16'h0090, 1'b1, 5'h01, 16'h2000, 16'h5000);
    set_mask(1'b0);
    IRQ_REQ_I <= 8'h20;
    repeat (4) @(posedge CLK_SYS_I);
    IRQ_REQ_I <= 8'h21;
    repeat (3) @(posedge CLK_SYS_I);
    t_entry(16'h6000, 16'h00a0, 1'b0, 5'h07, 16'h3500, 16'h5fff);
    IRQ_REQ_I <= 8'h00; BRK_REQ_I <= 1'b1;
    t_entry(16'h7000, 16'h00b0, 1'b0, 5'h01, 16'h2000, 16'h6fff);
    BRK_REQ_I <= 1'b0;
    print_verdict();
  end

  // Cuts a hang short; the full sequence needs well under a thousand cycles.
  initial begin
    repeat (5000) @(posedge CLK_SYS_I);
    fail_count++;
    $display("FAIL %0t watchdog expired before the sequence ended", $time);
    print_verdict();
  end
endmodule : esq_sequencer_test

bind esq_sequencer esq_seq_monitor chk_i (.CLK_SYS_I(CLK_SYS_I), .RST_N_I(RST_N_I),
  .INSTR_DONE_I(INSTR_DONE_I), .SWI_EXEC_I(SWI_EXEC_I), .RTI_EXEC_I(RTI_EXEC_I),
  .BRK_REQ_I(BRK_REQ_I), .RDATA_I(RDATA_I), .ADDR_O(ADDR_O), .RD_O(RD_O), .WR_O(WR_O),
  .CORE_HOLD_O(CORE_HOLD_O), .VEC_SEL_O(VEC_SEL_O), .IMASK_O(IMASK_O),
  .PC_LOAD_O(PC_LOAD_O), .PC_NEW_O(PC_NEW_O), .SP_LOAD_O(SP_LOAD_O),
  .SP_NEW_O(SP_NEW_O), .REG_LOAD_O(REG_LOAD_O));
